/* hdl/bwp_ctrl.sv */
/*
  Board wake and power-state controller: tracks S0/S1/S3/S4/S5, drives the
  main rails, LED and fans, restores state after AC loss and gates wake
  sources per state. Registers are reached over AHB-Lite.
  Assumes all wake, tach and AC inputs come from pins of other domains.
*/
// Behaviour
// - Fans enabled while in S0 or S1.
// - Fans disabled when off or in S3, S4 or S5.
// - Each fan has tachometer input, closed-loop speed, forced on or off.
// - After AC returns, restore prior on/off state per restore policy.
// - Soft-off command drops non-standby rails, standby stays.
// - Network wake frame detection raises a wake that powers up.
// - Modem ring wakes from S1 or S3 only while modem interrupt unmasked.
// - USB activity wakes only from S1 or S3.
// - PS/2 activity wakes only from S1 or S3.
// - Bus PME wakes from S1, S3, S4, S5 when its enable is set.
// - PCI Express wake wakes from S1, S3, S4, S5 without enable.
// - In S3 main supply off; LED amber if dual colour, else dark.
// - Permitted wake in S3 returns promptly to working state.
// - No S3 wake from echo-request ping while alert management enabled.
// - S5 wake by network frame or PME only when option enabled.
`timescale 1ns/1ps
module bwp_ctrl #(
  parameter int NFAN       = 2,
  parameter int WIN_CYCLES = bwp_pkg::TACH_WIN_CYCLES
) (
  input  wire logic                    clk_i,
  input  wire logic                    rst_n_i,
  input  wire logic                    clk_en_i,
  input  wire logic                    hsel_i,
  input  wire logic [31:0]             haddr_i,
  input  wire logic [1:0]              htrans_i,
  input  wire logic                    hwrite_i,
  input  wire logic [2:0]              hsize_i,
  input  wire logic [31:0]             hwdata_i,
  input  wire logic                    hready_i,
  output logic [31:0]                  hrdata_o,
  output logic                         hreadyout_o,
  output logic                         hresp_o,
  input  wire logic                    ac_ok_i,
  input  wire logic [bwp_pkg::SRC_W-1:0] wake_i,
  input  wire logic [NFAN-1:0]         tach_i,
  output logic [NFAN-1:0]              fan_pwm_o,
  output logic                         main_rails_on_o,
  output logic                         led_green_o,
  output logic                         led_amber_o,
  output logic                         irq_o
);

  // ----------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------
  localparam int SW = bwp_pkg::SRC_W + NFAN + 1;
  logic [SW-1:0] s1_q;
  logic [SW-1:0] s2_q;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_q <= '0;
      s2_q <= '0;
    end else if (clk_en_i) begin
      s1_q <= {ac_ok_i, tach_i, wake_i};
      s2_q <= s1_q;
    end
  end

  logic [bwp_pkg::SRC_W-1:0] src;
  logic [NFAN-1:0]           tach_s;
  logic                      ac_s;
  logic                      ac_q;
  assign src    = s2_q[bwp_pkg::SRC_W-1:0];
  assign tach_s = s2_q[bwp_pkg::SRC_W +: NFAN];
  assign ac_s   = s2_q[SW-1];

  // ----------------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------------
  logic        dph_q;
  logic        dwr_q;
  logic [7:0]  dad_q;
  logic        take;
  assign take        = hsel_i && hready_i && htrans_i[1];
  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dph_q <= 1'b0;
      dwr_q <= 1'b0;
      dad_q <= 8'h0;
    end else if (clk_en_i) begin
      dph_q <= take;
      dwr_q <= take && hwrite_i;
      dad_q <= {haddr_i[7:2], 2'b00};
    end
  end

  function automatic logic wr_hit(input logic w, input logic [7:0] a, input logic [7:0] o);
    return w && (a == o);
  endfunction : wr_hit

  // ----------------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------------
  logic [6:0]  ctrl_q;
  logic [2:0]  msk_q;
  logic [17:0] fan_cfg_q [NFAN];
  logic [2:0]  cmd;

  assign cmd = wr_hit(dwr_q, dad_q, bwp_pkg::OFS_CMD) ? hwdata_i[2:0] : bwp_pkg::CMD_NONE;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_q <= bwp_pkg::CTRL_RESET;
      msk_q  <= '0;
    end else if (clk_en_i) begin
      if (wr_hit(dwr_q, dad_q, bwp_pkg::OFS_CTRL)) begin
        ctrl_q <= hwdata_i[6:0];
      end
      if (wr_hit(dwr_q, dad_q, bwp_pkg::OFS_IRQ_MSK)) begin
        msk_q <= hwdata_i[2:0];
      end
    end
  end

  logic [15:0] tach_cnt [NFAN];

  // ----------------------------------------------------------------------
  // Fan channels
  // ----------------------------------------------------------------------
  logic fan_allow;
  genvar gi;
  generate
    for (gi = 0; gi < NFAN; gi++) begin : g_fan
      always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          fan_cfg_q[gi] <= bwp_pkg::FAN_RESET;
        end else if (clk_en_i && wr_hit(dwr_q, dad_q, 8'(bwp_pkg::OFS_FAN0 + 4 * gi))) begin
          fan_cfg_q[gi] <= hwdata_i[17:0];
        end
      end
      bwp_fan #(
        .WIN_CYCLES (WIN_CYCLES)
      ) u_fan (
        .clk_i    (clk_i),
        .rst_n_i  (rst_n_i),
        .en_i     (clk_en_i),
        .allow_i  (fan_allow),
        .mode_i   (fan_cfg_q[gi][bwp_pkg::FAN_MODE_LSB +: 2]),
        .target_i (fan_cfg_q[gi][7:0]),
        .tach_i   (tach_s[gi]),
        .pwm_o    (fan_pwm_o[gi]),
        .count_o  (tach_cnt[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Wake gating
  // ----------------------------------------------------------------------
  bwp_pkg::bwp_state_e st_q;
  bwp_pkg::bwp_state_e st_d;
  logic                last_on_q;
  logic                wake;
  logic                s13;
  logic                s45;

  assign s13 = (st_q == bwp_pkg::ST_S1) || (st_q == bwp_pkg::ST_S3);
  assign s45 = (st_q == bwp_pkg::ST_S4) || (st_q == bwp_pkg::ST_S5);

  function automatic logic lan_pme_ok(input bwp_pkg::bwp_state_e s, input logic s5en);
    return (s != bwp_pkg::ST_S0) && (s != bwp_pkg::ST_S5 || s5en);
  endfunction : lan_pme_ok

  always_comb begin
    wake = 1'b0;
    if (src[bwp_pkg::SRC_LAN] && lan_pme_ok(st_q, ctrl_q[bwp_pkg::CTRL_S5_LAN_PME_ENABLE])) begin
      wake = 1'b1;
    end
    if (src[bwp_pkg::SRC_RING] && s13 && ctrl_q[bwp_pkg::CTRL_MODEM_IRQ_UNMASK]) begin
      wake = 1'b1;
    end
    if ((src[bwp_pkg::SRC_USB] || src[bwp_pkg::SRC_PS2]) && s13) begin
      wake = 1'b1;
    end
    if (src[bwp_pkg::SRC_PME] && ctrl_q[bwp_pkg::CTRL_BUS_EVENT_WAKE_ENABLE]
        && lan_pme_ok(st_q, ctrl_q[bwp_pkg::CTRL_S5_LAN_PME_ENABLE])) begin
      wake = 1'b1;
    end
    if (src[bwp_pkg::SRC_PCIE] && (s13 || s45)) begin
      wake = 1'b1;
    end
    if (src[bwp_pkg::SRC_PING] && !ctrl_q[bwp_pkg::CTRL_ALERT_MGMT_ENABLE]
        && lan_pme_ok(st_q, ctrl_q[bwp_pkg::CTRL_S5_LAN_PME_ENABLE])) begin
      wake = 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Power state machine
  // ----------------------------------------------------------------------
  logic ac_rise;
  assign ac_rise = ac_s && !ac_q;

  always_comb begin
    st_d = st_q;
    case (st_q)
      bwp_pkg::ST_S0: begin
        case (cmd)
          bwp_pkg::CMD_SLEEP_S1: st_d = bwp_pkg::ST_S1;
          bwp_pkg::CMD_SLEEP_S3: st_d = bwp_pkg::ST_S3;
          bwp_pkg::CMD_SLEEP_S4: st_d = bwp_pkg::ST_S4;
          bwp_pkg::CMD_SOFT_OFF: st_d = bwp_pkg::ST_S5;
          default:               st_d = bwp_pkg::ST_S0;
        endcase
      end
      bwp_pkg::ST_S1, bwp_pkg::ST_S3, bwp_pkg::ST_S4, bwp_pkg::ST_S5: begin
        if (wake) begin
          st_d = bwp_pkg::ST_S0;
        end else if (cmd == bwp_pkg::CMD_SOFT_OFF) begin
          st_d = bwp_pkg::ST_S5;
        end
      end
      default: st_d = bwp_pkg::ST_S5;
    endcase
    if (!ac_s) begin
      st_d = bwp_pkg::ST_S5;
    end else if (ac_rise) begin
      case (ctrl_q[bwp_pkg::CTRL_RESTORE_LSB +: 2])
        bwp_pkg::RESTORE_LAST:     st_d = last_on_q ? bwp_pkg::ST_S0 : bwp_pkg::ST_S5;
        bwp_pkg::RESTORE_POWER_ON: st_d = bwp_pkg::ST_S0;
        default:                   st_d = bwp_pkg::ST_S5;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q      <= bwp_pkg::ST_S5;
      ac_q      <= 1'b0;
      last_on_q <= 1'b0;
    end else if (clk_en_i) begin
      st_q <= st_d;
      ac_q <= ac_s;
      if (ac_s) begin
        last_on_q <= (st_q != bwp_pkg::ST_S5);
      end
    end
  end

  assign fan_allow = (st_q == bwp_pkg::ST_S0) || (st_q == bwp_pkg::ST_S1);

  bwp_pkg::bwp_power_s pwr_q;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pwr_q <= '0;
    end else if (clk_en_i) begin
      pwr_q.main_rails_on <= (st_d == bwp_pkg::ST_S0) || (st_d == bwp_pkg::ST_S1);
      pwr_q.led_green     <= (st_d == bwp_pkg::ST_S0);
      pwr_q.led_amber     <= (st_d == bwp_pkg::ST_S3) && ctrl_q[bwp_pkg::CTRL_DUAL_LED];
    end
  end
  assign main_rails_on_o = pwr_q.main_rails_on;
  assign led_green_o     = pwr_q.led_green;
  assign led_amber_o     = pwr_q.led_amber;

  // ----------------------------------------------------------------------
  // Interrupts and read data
  // ----------------------------------------------------------------------
  logic [bwp_pkg::IRQ_W-1:0] ist_q;
  logic [bwp_pkg::IRQ_W-1:0] ev;
  logic [bwp_pkg::IRQ_W-1:0] clr;
  assign ev[bwp_pkg::IRQ_WAKE]    = (st_q != bwp_pkg::ST_S0) && (st_d == bwp_pkg::ST_S0) && !ac_rise;
  assign ev[bwp_pkg::IRQ_AC_BACK] = ac_rise;
  assign ev[bwp_pkg::IRQ_OFF]     = (st_q != bwp_pkg::ST_S5) && (st_d == bwp_pkg::ST_S5);
  assign clr = wr_hit(dwr_q, dad_q, bwp_pkg::OFS_IRQ_ST) ? hwdata_i[2:0] : '0;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ist_q <= '0;
    end else if (clk_en_i) begin
      ist_q <= (ist_q & ~clr) | ev;
    end
  end
  assign irq_o = |(ist_q & msk_q);

  always_comb begin
    hrdata_o = 32'h0;
    if (dph_q && !dwr_q) begin
      case (dad_q)
        bwp_pkg::OFS_CTRL:    hrdata_o = {25'h0, ctrl_q};
        bwp_pkg::OFS_STATE:   hrdata_o = {26'h0, last_on_q, st_q};
        bwp_pkg::OFS_IRQ_ST:  hrdata_o = {29'h0, ist_q};
        bwp_pkg::OFS_IRQ_MSK: hrdata_o = {29'h0, msk_q};
        bwp_pkg::OFS_FAN0:    hrdata_o = {14'h0, fan_cfg_q[0]};
        bwp_pkg::OFS_FAN1:    hrdata_o = {14'h0, fan_cfg_q[NFAN-1]};
        bwp_pkg::OFS_TACH0:   hrdata_o = {16'h0, tach_cnt[0]};
        bwp_pkg::OFS_TACH1:   hrdata_o = {16'h0, tach_cnt[NFAN-1]};
        default:              hrdata_o = 32'h0;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  sequence q_wake_in_s0;
    st_q == bwp_pkg::ST_S0 && src != '0 && ac_s && !ac_rise;
  endsequence

  a_fan_on_work: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    clk_en_i && (st_q == bwp_pkg::ST_S0 || st_q == bwp_pkg::ST_S1)
      && fan_cfg_q[0][bwp_pkg::FAN_MODE_LSB +: 2] == bwp_pkg::FAN_FULL_ON |=> fan_pwm_o[0])
    else $error("fan not running in S0 or S1");
  a_fan_off_sleep: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    clk_en_i && (st_q == bwp_pkg::ST_S3 || st_q == bwp_pkg::ST_S5) ##1 clk_en_i
      |-> fan_pwm_o == '0)
    else $error("fan running in deep sleep");
  a_rails_off_cmd: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    clk_en_i && st_q == bwp_pkg::ST_S0 && cmd == bwp_pkg::CMD_SOFT_OFF && ac_s
      |=> !main_rails_on_o && st_q == bwp_pkg::ST_S5)
    else $error("rails still on after soft off");
  a_s3_led_amber: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    clk_en_i && st_d == bwp_pkg::ST_S3
      |=> !main_rails_on_o && led_amber_o == $past(ctrl_q[bwp_pkg::CTRL_DUAL_LED]))
    else $error("S3 supply or LED wrong");
  a_usb_only_s13: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    clk_en_i && st_q == bwp_pkg::ST_S4 && src == 7'(1 << bwp_pkg::SRC_USB) && ac_s
      && cmd == bwp_pkg::CMD_NONE |=> st_q == bwp_pkg::ST_S4)
    else $error("USB woke from S4");
  a_pcie_wake_s5: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    clk_en_i && st_q == bwp_pkg::ST_S5 && src[bwp_pkg::SRC_PCIE] && ac_s && !ac_rise
      |=> st_q == bwp_pkg::ST_S0 ##1 main_rails_on_o || !clk_en_i)
    else $error("PCIe wake ignored in S5");
  a_pme_needs_en: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    clk_en_i && st_q != bwp_pkg::ST_S0 && src == 7'(1 << bwp_pkg::SRC_PME) && ac_s
      && !ac_rise && !ctrl_q[bwp_pkg::CTRL_BUS_EVENT_WAKE_ENABLE]
      && cmd == bwp_pkg::CMD_NONE |=> st_q == $past(st_q))
    else $error("PME woke without enable");
  a_s5_lan_gate: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    clk_en_i && st_q == bwp_pkg::ST_S5 && !ctrl_q[bwp_pkg::CTRL_S5_LAN_PME_ENABLE]
      && (src == 7'(1 << bwp_pkg::SRC_LAN) || src == 7'(1 << bwp_pkg::SRC_PME))
      && ac_s && !ac_rise && cmd == bwp_pkg::CMD_NONE |=> st_q == bwp_pkg::ST_S5)
    else $error("S5 woke by network or PME with option off");
  a_s0_ignore: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    q_wake_in_s0 and (clk_en_i && cmd == bwp_pkg::CMD_NONE) |=> st_q == bwp_pkg::ST_S0)
    else $error("wake changed state in S0");
  a_irq_sticky: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    clk_en_i && ev[bwp_pkg::IRQ_OFF] |=> ist_q[bwp_pkg::IRQ_OFF])
    else $error("off event lost");

endmodule : bwp_ctrl

/* hdl/bwp_pkg.sv */
/*
  Package for the board wake and power-state controller: register map, field
  positions, reset values, state encodings and carrier structs.
  Assumes a 100 MHz standby clock and a single AHB-Lite slave port.
*/
package bwp_pkg;

  // ----------------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_STATE   = 8'h04;
  localparam logic [7:0] OFS_CMD     = 8'h08;
  localparam logic [7:0] OFS_IRQ_ST  = 8'h0c;
  localparam logic [7:0] OFS_IRQ_MSK = 8'h10;
  localparam logic [7:0] OFS_FAN0    = 8'h14;
  localparam logic [7:0] OFS_FAN1    = 8'h18;
  localparam logic [7:0] OFS_TACH0   = 8'h1c;
  localparam logic [7:0] OFS_TACH1   = 8'h20;

  // ----------------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------------
  localparam int CTRL_BUS_EVENT_WAKE_ENABLE = 0;
  localparam int CTRL_S5_LAN_PME_ENABLE     = 1;
  localparam int CTRL_MODEM_IRQ_UNMASK      = 2;
  localparam int CTRL_ALERT_MGMT_ENABLE     = 3;
  localparam int CTRL_DUAL_LED              = 4;
  localparam int CTRL_RESTORE_LSB           = 5;
  localparam logic [6:0] CTRL_RESET         = 7'h00;

  // Restore policy after AC loss.
  localparam logic [1:0] RESTORE_STAY_OFF = 2'h0;
  localparam logic [1:0] RESTORE_LAST     = 2'h1;
  localparam logic [1:0] RESTORE_POWER_ON = 2'h2;

  // Command register codes (write only, acted on once).
  localparam logic [2:0] CMD_NONE     = 3'h0;
  localparam logic [2:0] CMD_SLEEP_S1 = 3'h1;
  localparam logic [2:0] CMD_SLEEP_S3 = 3'h3;
  localparam logic [2:0] CMD_SLEEP_S4 = 3'h4;
  localparam logic [2:0] CMD_SOFT_OFF = 3'h5;

  // Interrupt status bit positions.
  localparam int IRQ_WAKE    = 0;
  localparam int IRQ_AC_BACK = 1;
  localparam int IRQ_OFF     = 2;
  localparam int IRQ_W       = 3;

  // Wake source bit positions.
  localparam int SRC_LAN   = 0;
  localparam int SRC_RING  = 1;
  localparam int SRC_USB   = 2;
  localparam int SRC_PS2   = 3;
  localparam int SRC_PME   = 4;
  localparam int SRC_PCIE  = 5;
  localparam int SRC_PING  = 6;
  localparam int SRC_W     = 7;

  // Fan control fields.
  localparam int FAN_MODE_LSB = 16;
  localparam logic [1:0] FAN_AUTO     = 2'h0;
  localparam logic [1:0] FAN_FULL_ON  = 2'h1;
  localparam logic [1:0] FAN_FULL_OFF = 2'h2;
  localparam logic [17:0] FAN_RESET   = 18'h00080;

  // Tachometer measurement window.
  localparam int TACH_WIN_US     = 1000;
  localparam int CLK_MHZ         = 100;
  localparam int TACH_WIN_CYCLES = TACH_WIN_US * CLK_MHZ;

  // ----------------------------------------------------------------------
  // Power states
  // ----------------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_S0 = 5'b00001,
    ST_S1 = 5'b00010,
    ST_S3 = 5'b00100,
    ST_S4 = 5'b01000,
    ST_S5 = 5'b10000
  } bwp_state_e;

  typedef struct packed {
    logic main_rails_on;
    logic led_green;
    logic led_amber;
  } bwp_power_s;

endpackage : bwp_pkg

/* hdl/bwp_fan.sv */
/*
  One fan channel: PWM drive with closed-loop duty trim from a tachometer
  count, plus forced full-on and full-off modes.
  Assumes tach_i is already synchronised to clk_i.
*/
`timescale 1ns/1ps
module bwp_fan #(
  parameter int WIN_CYCLES = bwp_pkg::TACH_WIN_CYCLES
) (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        en_i,
  input  wire logic        allow_i,
  input  wire logic [1:0]  mode_i,
  input  wire logic [7:0]  target_i,
  input  wire logic        tach_i,
  output logic             pwm_o,
  output logic [15:0]      count_o
);

  logic [31:0] win_q;
  logic [15:0] pulses_q;
  logic [7:0]  duty_q;
  logic [7:0]  ph_q;
  logic        tach_q;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      win_q    <= 32'h0;
      pulses_q <= 16'h0;
      count_o  <= 16'h0;
      tach_q   <= 1'b0;
    end else if (en_i) begin
      tach_q <= tach_i;
      if (win_q == 32'(WIN_CYCLES - 1)) begin
        win_q    <= 32'h0;
        count_o  <= pulses_q;
        pulses_q <= 16'h0;
      end else begin
        win_q <= win_q + 32'h1;
        if (tach_i && !tach_q) begin
          pulses_q <= pulses_q + 16'h1;
        end
      end
    end
  end

  // Closed loop: duty steps toward the target pulse count each window.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      duty_q <= 8'h80;
    end else if (en_i && win_q == 32'(WIN_CYCLES - 1)) begin
      if (pulses_q < {8'h0, target_i} && duty_q != 8'hff) begin
        duty_q <= duty_q + 8'h1;
      end else if (pulses_q > {8'h0, target_i} && duty_q != 8'h00) begin
        duty_q <= duty_q - 8'h1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ph_q  <= 8'h0;
      pwm_o <= 1'b0;
    end else if (en_i) begin
      ph_q <= ph_q + 8'h1;
      if (!allow_i || mode_i == bwp_pkg::FAN_FULL_OFF) begin
        pwm_o <= 1'b0;
      end else if (mode_i == bwp_pkg::FAN_FULL_ON) begin
        pwm_o <= 1'b1;
      end else begin
        pwm_o <= (ph_q < duty_q);
      end
    end
  end

endmodule : bwp_fan

/* bench/bwp_src_model.sv */
/*
  Model of the far side: wake sources, AC sense and fan tachometers.
  Assumes fire_i bits are one-cycle pulses from the bench, clocked by clk_i.
*/
`timescale 1ns/1ps
module bwp_src_model (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic [6:0] fire_i,
  input  wire logic       ac_i,
  input  wire logic [1:0] pwm_i,
  output logic [6:0]      wake_o,
  output logic            ac_ok_o,
  output logic [1:0]      tach_o
);
  logic [2:0] hold_q [7];
  logic [2:0] div_q;

  // A fired source holds its request level for seven cycles, then drops it.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int k = 0; k < 7; k++) hold_q[k] <= 3'h0;
      div_q <= 3'h0;
    end else begin
      for (int k = 0; k < 7; k++) begin
        if (fire_i[k]) hold_q[k] <= 3'h7;
        else if (hold_q[k] != 3'h0) hold_q[k] <= hold_q[k] - 3'h1;
      end
      div_q <= div_q + 3'h1;
    end
  end

  always_comb begin
    for (int k = 0; k < 7; k++) wake_o[k] = (hold_q[k] != 3'h0);
  end

  // A driven fan spins and gives one tach pulse every eight cycles.
  assign tach_o  = {2{div_q[2]}} & pwm_i;
  assign ac_ok_o = ac_i;
endmodule : bwp_src_model

/* bench/bwp_ctrl_test.sv */
/*
  Self-checking bench for the wake and power-state controller.
  Assumes the bwp_pkg register map and state encoding and a 100 MHz clock.
*/
`timescale 1ns/1ps
module bwp_ctrl_test;
  typedef struct packed {
    logic [6:0]          ctrl;
    logic [2:0]          cmd;
    int                  src;
    bwp_pkg::bwp_state_e exp;
  } bwp_row_s;

  logic        clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        hsel = 1'b0, hwrite = 1'b0, ac_req = 1'b1, clk_en = 1'b1;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0]  htrans = 2'h0, fan_pwm, tach;
  logic [2:0]  hsize = 3'h2;
  logic [6:0]  fire = 7'h0, wake;
  logic        hreadyout, ac_ok, rails, led_a, irq, led_g, hresp;
  int          checks = 0, mismatches = 0, cycles = 0;
  bwp_row_s    rows [15] = '{
    '{7'h00, bwp_pkg::CMD_SLEEP_S1, bwp_pkg::SRC_USB,  bwp_pkg::ST_S0},
    '{7'h00, bwp_pkg::CMD_SLEEP_S3, bwp_pkg::SRC_PS2,  bwp_pkg::ST_S0},
    '{7'h00, bwp_pkg::CMD_SLEEP_S4, bwp_pkg::SRC_USB,  bwp_pkg::ST_S4},
    '{7'h00, bwp_pkg::CMD_SLEEP_S4, bwp_pkg::SRC_PS2,  bwp_pkg::ST_S4},
    '{7'h00, bwp_pkg::CMD_SLEEP_S4, bwp_pkg::SRC_PCIE, bwp_pkg::ST_S0},
    '{7'h00, bwp_pkg::CMD_SLEEP_S4, bwp_pkg::SRC_PME,  bwp_pkg::ST_S4},
    '{7'h01, bwp_pkg::CMD_SLEEP_S3, bwp_pkg::SRC_PME,  bwp_pkg::ST_S0},
    '{7'h01, bwp_pkg::CMD_SOFT_OFF, bwp_pkg::SRC_PME,  bwp_pkg::ST_S5},
    '{7'h03, bwp_pkg::CMD_SOFT_OFF, bwp_pkg::SRC_LAN,  bwp_pkg::ST_S0},
    '{7'h00, bwp_pkg::CMD_SLEEP_S3, bwp_pkg::SRC_RING, bwp_pkg::ST_S3},
    '{7'h04, bwp_pkg::CMD_SLEEP_S1, bwp_pkg::SRC_RING, bwp_pkg::ST_S0},
    '{7'h08, bwp_pkg::CMD_SLEEP_S3, bwp_pkg::SRC_PING, bwp_pkg::ST_S3},
    '{7'h10, bwp_pkg::CMD_SLEEP_S1, bwp_pkg::SRC_LAN,  bwp_pkg::ST_S0},
    '{7'h10, bwp_pkg::CMD_SOFT_OFF, bwp_pkg::SRC_PCIE, bwp_pkg::ST_S0},
    '{7'h10, bwp_pkg::CMD_SLEEP_S3, bwp_pkg::SRC_USB,  bwp_pkg::ST_S0}
  };

  bwp_ctrl #(.NFAN(2), .WIN_CYCLES(50)) bwp_ctrl_i (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
    .hready_i(hreadyout), .hrdata_o(hrdata), .hreadyout_o(hreadyout), .hresp_o(hresp),
    .ac_ok_i(ac_ok), .wake_i(wake), .tach_i(tach), .fan_pwm_o(fan_pwm),
    .main_rails_on_o(rails), .led_green_o(led_g), .led_amber_o(led_a), .irq_o(irq));

  bwp_src_model bwp_src_model_i (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .fire_i(fire), .ac_i(ac_req), .pwm_i(fan_pwm),
    .wake_o(wake), .ac_ok_o(ac_ok), .tach_o(tach));

  always #5 clk_i = ~clk_i;

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : stop_test

  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      mismatches++;
      stop_test();
    end
  end

  task automatic check(input string n, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, exp, got);
    end
  endtask : check

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clk_i);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge clk_i); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= w ? d : 32'h0;
    do @(posedge clk_i); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : ahb

  task automatic fire_src(input int s);
    @(posedge clk_i);
    fire <= 7'h1 << s;
    @(posedge clk_i);
    fire <= 7'h0;
    repeat (16) @(posedge clk_i);
  endtask : fire_src

  // Reads the state back and checks rails, fans and amber LED against it.
  task automatic look(input bwp_pkg::bwp_state_e s, input logic [6:0] c);
    logic on;
    repeat (4) @(posedge clk_i);
    ahb(1'b0, bwp_pkg::OFS_STATE, 32'h0, rd);
    @(negedge clk_i);
    on = (s == bwp_pkg::ST_S0) || (s == bwp_pkg::ST_S1);
    check("state", 32'(rd[4:0]), 32'(s));
    check("rails", 32'(rails), 32'(on));
    check("fans", 32'(fan_pwm), {30'h0, {2{on}}});
    check("amber", 32'(led_a), 32'(s == bwp_pkg::ST_S3 && c[4]));
    check("green", 32'(led_g), 32'(s == bwp_pkg::ST_S0));
    check("hresp", 32'(hresp), 32'h0);
  endtask : look

  function automatic bwp_pkg::bwp_state_e to_state(input logic [2:0] c);
    case (c)
      bwp_pkg::CMD_SLEEP_S1: return bwp_pkg::ST_S1;
      bwp_pkg::CMD_SLEEP_S3: return bwp_pkg::ST_S3;
      bwp_pkg::CMD_SLEEP_S4: return bwp_pkg::ST_S4;
      default: return bwp_pkg::ST_S5;
    endcase
  endfunction : to_state

  task automatic ac_cycle(input logic [6:0] c, input bwp_pkg::bwp_state_e s);
    ahb(1'b1, bwp_pkg::OFS_CTRL, {25'h0, c}, rd);
    ac_req <= 1'b0;
    repeat (10) @(posedge clk_i);
    look(bwp_pkg::ST_S5, c);
    ac_req <= 1'b1;
    repeat (10) @(posedge clk_i);
    look(s, c);
  endtask : ac_cycle

  initial begin
    repeat (20) @(posedge clk_i);
    rst_n_i <= 1'b1;
    look(bwp_pkg::ST_S5, 7'h00);
    ahb(1'b0, bwp_pkg::OFS_CTRL, 32'h0, rd);
    check("ctrl_rst", rd, 32'(bwp_pkg::CTRL_RESET));
    ahb(1'b0, bwp_pkg::OFS_FAN1, 32'h0, rd);
    check("fan_rst", rd, 32'(bwp_pkg::FAN_RESET));
    ahb(1'b1, 8'h40, 32'h5, rd);
    ahb(1'b0, 8'h40, 32'h0, rd);
    check("unmapped", rd, 32'h0);
    ahb(1'b1, bwp_pkg::OFS_FAN0, 32'h00010080, rd);
    ahb(1'b1, bwp_pkg::OFS_FAN1, 32'h00010080, rd);
    foreach (rows[i]) begin
      ahb(1'b1, bwp_pkg::OFS_CTRL, {25'h0, rows[i].ctrl}, rd);
      fire_src(bwp_pkg::SRC_PCIE);
      ahb(1'b1, bwp_pkg::OFS_CMD, {29'h0, rows[i].cmd}, rd);
      look(to_state(rows[i].cmd), rows[i].ctrl);
      fire_src(rows[i].src);
      look(rows[i].exp, rows[i].ctrl);
    end
    repeat (100) @(posedge clk_i);
    ahb(1'b0, bwp_pkg::OFS_TACH0, 32'h0, rd);
    check("tach_seen", 32'(rd != 32'h0), 32'h1);
    ahb(1'b1, bwp_pkg::OFS_FAN0, 32'h00020080, rd);
    repeat (4) @(negedge clk_i);
    check("fan0_off", 32'(fan_pwm[0]), 32'h0);
    ahb(1'b1, bwp_pkg::OFS_FAN0, 32'h00010080, rd);
    ahb(1'b1, bwp_pkg::OFS_IRQ_ST, 32'h7, rd);
    ahb(1'b1, bwp_pkg::OFS_IRQ_MSK, 32'h2, rd);
    @(negedge clk_i);
    check("irq_idle", 32'(irq), 32'h0);
    ac_cycle(7'h20, bwp_pkg::ST_S0);
    check("irq_on", 32'(irq), 32'h1);
    ahb(1'b1, bwp_pkg::OFS_IRQ_ST, 32'h2, rd);
    @(negedge clk_i);
    check("irq_clr", 32'(irq), 32'h0);
    ac_cycle(7'h00, bwp_pkg::ST_S5);
    @(posedge clk_i);
    clk_en <= 1'b0;
    fire_src(bwp_pkg::SRC_PCIE);
    clk_en <= 1'b1;
    look(bwp_pkg::ST_S5, 7'h00);
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    look(bwp_pkg::ST_S5, 7'h00);
    stop_test();
  end
endmodule : bwp_ctrl_test
